// ### hdl/iorp_map.vh
// constants for the i/o processor register path: field positions, widths, reset values, sequencer state codes
// included by hdl/iorp_top.v only
`ifndef IORP_MAP_VH
`define IORP_MAP_VH

`define IORP_CMD_W 12
`define IORP_WORD_W 16
`define IORP_DEVNUM_W 8
`define IORP_CMD_SVC_BIT 0
`define IORP_CMD_OP_LSB 1
`define IORP_CMD_OP_MSB 3
`define IORP_CMD_DEV_LSB 4
`define IORP_CMD_DEV_MSB 11
`define IORP_CMD_RST 12'h000
`define IORP_WORD_RST 16'h0000
`define IORP_DEV_RST 8'h00

// multiplexed sequencer states
`define IORP_MS_IDLE 3'h0
`define IORP_MS_POLL 3'h1
`define IORP_MS_ADDR 3'h2
`define IORP_MS_TABLE 3'h3
`define IORP_MS_COPY 3'h4
`define IORP_MS_COUNT 3'h5
`define IORP_MS_DATA 3'h6

// direct sequencer states
`define IORP_DS_IDLE 2'h0
`define IORP_DS_POLL 2'h1
`define IORP_DS_ADDR 2'h2
`define IORP_DS_DATA 2'h3

// interrupt sequencer states
`define IORP_IS_IDLE 2'h0
`define IORP_IS_POLL 2'h1
`define IORP_IS_LOAD 2'h2

`endif

// ### hdl/iorp_top.v
// i/o processor register path: direct and multiplexed transfers between the processor,
// the central data bus and the i/o bus, plus interrupt device number capture.
// assumes all inputs are synchronous to REF_CLK_I and that the memory-side request logic
// supplies the select and in-process strobes; bus line levels are resolved outside.
`timescale 1ns/1ps
`include "iorp_map.vh"

module iorp_top (
	input wire REF_CLK_I,
	input wire SYS_RST_I,
	input wire [11:0] PROC_WORD_I,
	input wire [15:0] PROC_DATA_I,
	input wire COMMAND_REG_LOAD_I,
	input wire DIRECT_DATA_LOAD_I,
	input wire IO_COMMAND_CODE_I,
	input wire DIRECT_IN_READ_I,
	input wire DONE_FLAG_CLEAR_I,
	input wire DIRECT_START_I,
	input wire [15:0] IO_BUS_DATA_I,
	input wire [7:0] IO_BUS_DEVNUM_I,
	input wire [2:0] IO_BUS_CMD_I,
	input wire SVC_IN_I,
	input wire MASK_RETURN_I,
	input wire CHANNEL_REQUEST_I,
	input wire INTR_REQUEST_I,
	input wire INTR_ACKNOWLEDGE_I,
	input wire SYSTEM_PARITY_FAULT_I,
	input wire MEMORY_ADDR_PARITY_FAULT_I,
	input wire FAULT_CLEAR_I,
	input wire [15:0] CDB_DATA_I,
	input wire IO_TRANSFER_ACTIVE_I,
	input wire HIGH_WORD_SELECT_I,
	input wire LOW_WORD_SELECT_I,
	output reg [15:0] S_BUS_O,
	output reg S_BUS_OE_O,
	output reg [15:0] IO_BUS_DATA_O,
	output reg IO_BUS_DATA_OE_O,
	output reg [2:0] IO_BUS_CMD_O,
	output reg [7:0] IO_BUS_DEVNUM_O,
	output reg IO_BUS_ADDR_OE_O,
	output reg [15:0] CDB_DATA_O,
	output reg CDB_DATA_OE_O,
	output reg SVC_OUT_O,
	output reg PRIORITY_POLL_O,
	output reg INTR_POLL_O,
	output reg TRANSFER_ERROR_O,
	output reg DONE_FLAG_O,
	output reg HIGH_REQUEST_O,
	output reg LOW_REQUEST_O,
	output reg IN_BUF_READY_O
);

	reg [11:0] io_command_control_reg;
	reg [15:0] direct_out_buffer;
	reg [7:0] intr_device_number;
	reg [15:0] direct_in_or_mux_addr;
	reg [15:0] mux_out_buffer;
	reg [1:0] ds;
	reg [2:0] ms;
	reg [1:0] is;
	reg direct_xfer_armed;
	reg addr_parity_fault;
	reg svc_out_ff;
	// two-entry input buffer; entry 0 is the head presented to the data bus
	reg [15:0] ibuf [0:1];
	reg [1:0] ibuf_cnt;

	wire data_word_gate = (ds == `IORP_DS_DATA);
	wire address_word_gate = (ds == `IORP_DS_ADDR);
	wire table_word_gate = (ms == `IORP_MS_TABLE);
	wire bus_data_strobe = SVC_IN_I;
	wire low_request_init = (ms == `IORP_MS_DATA) && bus_data_strobe && (ibuf_cnt != 2'h2);
	wire in_buffer_load = low_request_init;
	wire table_entry_transfer = (ms == `IORP_MS_COPY) && (ibuf_cnt != 2'h2);
	wire count_enable = (ms == `IORP_MS_COUNT);
	wire addr_buffer_store_en = (ms == `IORP_MS_ADDR) || data_word_gate;
	wire intr_number_load = (is == `IORP_IS_POLL) && INTR_ACKNOWLEDGE_I;
	wire ibuf_push = in_buffer_load || table_entry_transfer;
	// no pop while the count step rewrites an entry, so the flags track the buffer
	wire ibuf_pop = HIGH_WORD_SELECT_I && (ibuf_cnt != 2'h0) && !count_enable;
	wire [15:0] push_word = table_entry_transfer ? mux_out_buffer : IO_BUS_DATA_I;
	wire mux_busy = (ms != `IORP_MS_IDLE);
	reg [2:0] next_ms;
	reg [1:0] next_ds;

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I)
			io_command_control_reg <= `IORP_CMD_RST;
		else if (COMMAND_REG_LOAD_I)
			io_command_control_reg <= PROC_WORD_I;
	end

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I)
			direct_out_buffer <= `IORP_WORD_RST;
		else if (DIRECT_DATA_LOAD_I)
			direct_out_buffer <= PROC_DATA_I;
	end

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I)
			intr_device_number <= `IORP_DEV_RST;
		else if (intr_number_load)
			intr_device_number <= IO_BUS_DEVNUM_I;
	end

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			is <= `IORP_IS_IDLE;
			INTR_POLL_O <= 1'b0;
		end else begin
			case (is)
			`IORP_IS_IDLE: begin
				if (INTR_REQUEST_I) begin
					is <= `IORP_IS_POLL;
					INTR_POLL_O <= 1'b1;
				end
			end
			`IORP_IS_POLL: begin
				if (INTR_ACKNOWLEDGE_I) begin
					is <= `IORP_IS_LOAD;
					INTR_POLL_O <= 1'b0;
				end
			end
			`IORP_IS_LOAD: begin
				// wait for the request to drop so one request yields one capture
				if (!INTR_REQUEST_I && !INTR_ACKNOWLEDGE_I)
					is <= `IORP_IS_IDLE;
			end
			default: begin
				is <= `IORP_IS_IDLE;
				INTR_POLL_O <= 1'b0;
			end
			endcase
		end
	end

	always @* begin
		next_ds = ds;
		case (ds)
		`IORP_DS_IDLE: begin
			if (DIRECT_START_I && !mux_busy)
				next_ds = `IORP_DS_POLL;
		end
		`IORP_DS_POLL: begin
			if (SVC_IN_I)
				next_ds = `IORP_DS_ADDR;
		end
		`IORP_DS_ADDR: begin
			if (SVC_IN_I)
				next_ds = `IORP_DS_DATA;
		end
		`IORP_DS_DATA: begin
			if (SVC_IN_I)
				next_ds = `IORP_DS_IDLE;
		end
		default: next_ds = `IORP_DS_IDLE;
		endcase
	end

	always @* begin
		next_ms = ms;
		case (ms)
		`IORP_MS_IDLE: begin
			// direct start wins a tie so only one sequence owns the bus
			if (CHANNEL_REQUEST_I && ds == `IORP_DS_IDLE && !DIRECT_START_I)
				next_ms = `IORP_MS_POLL;
		end
		`IORP_MS_POLL: begin
			if (SVC_IN_I)
				next_ms = `IORP_MS_ADDR;
		end
		`IORP_MS_ADDR: begin
			// command line bit 0 high asks for a table fetch first
			if (bus_data_strobe)
				next_ms = IO_BUS_CMD_I[0] ? `IORP_MS_TABLE : `IORP_MS_DATA;
		end
		`IORP_MS_TABLE: begin
			if (SVC_IN_I)
				next_ms = `IORP_MS_COPY;
		end
		`IORP_MS_COPY: begin
			if (table_entry_transfer)
				next_ms = `IORP_MS_COUNT;
		end
		`IORP_MS_COUNT: next_ms = `IORP_MS_DATA;
		`IORP_MS_DATA: begin
			if (in_buffer_load || !CHANNEL_REQUEST_I)
				next_ms = `IORP_MS_IDLE;
		end
		default: next_ms = `IORP_MS_IDLE;
		endcase
	end

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			ds <= `IORP_DS_IDLE;
			ms <= `IORP_MS_IDLE;
		end else begin
			ds <= next_ds;
			ms <= next_ms;
		end
	end

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I)
			direct_xfer_armed <= 1'b0;
		else if (next_ds == `IORP_DS_ADDR || next_ds == `IORP_DS_DATA)
			direct_xfer_armed <= 1'b1;
		else if (DONE_FLAG_CLEAR_I)
			direct_xfer_armed <= 1'b0;
	end

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I)
			DONE_FLAG_O <= 1'b0;
		else if (direct_xfer_armed && (SVC_IN_I || svc_out_ff || MASK_RETURN_I))
			DONE_FLAG_O <= 1'b1;
		else if (DONE_FLAG_CLEAR_I)
			DONE_FLAG_O <= 1'b0;
	end

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I)
			addr_parity_fault <= 1'b0;
		else if (mux_busy && (SYSTEM_PARITY_FAULT_I || MEMORY_ADDR_PARITY_FAULT_I))
			addr_parity_fault <= 1'b1;
		else if (FAULT_CLEAR_I)
			addr_parity_fault <= 1'b0;
	end

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I)
			svc_out_ff <= 1'b0;
		else
			svc_out_ff <= io_command_control_reg[`IORP_CMD_SVC_BIT] || addr_parity_fault;
	end

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I)
			direct_in_or_mux_addr <= `IORP_WORD_RST;
		else if (bus_data_strobe && addr_buffer_store_en)
			direct_in_or_mux_addr <= IO_BUS_DATA_I;
	end

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I)
			mux_out_buffer <= `IORP_WORD_RST;
		else if (IO_TRANSFER_ACTIVE_I)
			mux_out_buffer <= CDB_DATA_I;
	end

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			ibuf_cnt <= 2'h0;
			ibuf[0] <= `IORP_WORD_RST;
			ibuf[1] <= `IORP_WORD_RST;
		end else if (count_enable) begin
			// the copied entry is the newest word; the count step adds two to it
			if (ibuf_cnt == 2'h2)
				ibuf[1] <= ibuf[1] + 16'h0002;
			else
				ibuf[0] <= ibuf[0] + 16'h0002;
		end else begin
			case ({ibuf_push, ibuf_pop})
			2'b10: begin
				if (ibuf_cnt == 2'h0)
					ibuf[0] <= push_word;
				else
					ibuf[1] <= push_word;
				ibuf_cnt <= ibuf_cnt + 2'h1;
			end
			2'b01: begin
				ibuf[0] <= ibuf[1];
				ibuf_cnt <= ibuf_cnt - 2'h1;
			end
			2'b11: begin
				if (ibuf_cnt == 2'h1)
					ibuf[0] <= push_word;
				else begin
					ibuf[0] <= ibuf[1];
					ibuf[1] <= push_word;
				end
			end
			default: ibuf_cnt <= ibuf_cnt;
			endcase
		end
	end

	// registered outputs
	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			S_BUS_O <= `IORP_WORD_RST;
			S_BUS_OE_O <= 1'b0;
			IO_BUS_DATA_O <= `IORP_WORD_RST;
			IO_BUS_DATA_OE_O <= 1'b0;
			IO_BUS_CMD_O <= 3'h0;
			IO_BUS_DEVNUM_O <= `IORP_DEV_RST;
			IO_BUS_ADDR_OE_O <= 1'b0;
			CDB_DATA_O <= `IORP_WORD_RST;
			CDB_DATA_OE_O <= 1'b0;
			SVC_OUT_O <= 1'b0;
			PRIORITY_POLL_O <= 1'b0;
			TRANSFER_ERROR_O <= 1'b0;
			HIGH_REQUEST_O <= 1'b0;
			LOW_REQUEST_O <= 1'b0;
			IN_BUF_READY_O <= 1'b1;
		end else begin
			S_BUS_OE_O <= IO_COMMAND_CODE_I || DIRECT_IN_READ_I;
			S_BUS_O <= DIRECT_IN_READ_I ? direct_in_or_mux_addr :
				(IO_COMMAND_CODE_I ? {8'h00, intr_device_number} : `IORP_WORD_RST);
			IO_BUS_DATA_OE_O <= (next_ds == `IORP_DS_DATA) || (next_ms == `IORP_MS_TABLE);
			IO_BUS_DATA_O <= (next_ds == `IORP_DS_DATA) ? direct_out_buffer :
				((next_ms == `IORP_MS_TABLE) ? mux_out_buffer : `IORP_WORD_RST);
			IO_BUS_ADDR_OE_O <= (next_ds == `IORP_DS_ADDR);
			IO_BUS_CMD_O <= io_command_control_reg[`IORP_CMD_OP_MSB:`IORP_CMD_OP_LSB];
			IO_BUS_DEVNUM_O <= io_command_control_reg[`IORP_CMD_DEV_MSB:`IORP_CMD_DEV_LSB];
			CDB_DATA_OE_O <= HIGH_WORD_SELECT_I || LOW_WORD_SELECT_I;
			CDB_DATA_O <= HIGH_WORD_SELECT_I ? ibuf[0] :
				(LOW_WORD_SELECT_I ? direct_in_or_mux_addr : `IORP_WORD_RST);
			SVC_OUT_O <= svc_out_ff;
			PRIORITY_POLL_O <= (next_ds == `IORP_DS_POLL) || (next_ms == `IORP_MS_POLL);
			TRANSFER_ERROR_O <= addr_parity_fault;
			HIGH_REQUEST_O <= (next_ibuf_nonempty(ibuf_cnt, ibuf_push, ibuf_pop));
			LOW_REQUEST_O <= (ms == `IORP_MS_ADDR) && bus_data_strobe;
			// stalls the sequencer when full so no word is lost
			IN_BUF_READY_O <= !next_ibuf_full(ibuf_cnt, ibuf_push, ibuf_pop);
		end
	end

	function next_ibuf_nonempty;
		input [1:0] cnt;
		input push;
		input pop;
		begin
			next_ibuf_nonempty = (cnt == 2'h2) || (cnt == 2'h1 && !(pop && !push)) || push;
		end
	endfunction

	function next_ibuf_full;
		input [1:0] cnt;
		input push;
		input pop;
		begin
			next_ibuf_full = (cnt == 2'h2 && !pop) || (cnt == 2'h1 && push && !pop);
		end
	endfunction

endmodule

// ### verification/io_processor_register_path_test.sv
// bench for the register path, channel model on the i/o bus
// drives all design inputs at the rising edge, samples at the falling edge
`timescale 1ns/1ps
module io_processor_register_path_test;
	reg REF_CLK_I, SYS_RST_I, COMMAND_REG_LOAD_I, DIRECT_DATA_LOAD_I, IO_COMMAND_CODE_I, DIRECT_IN_READ_I;
	reg DONE_FLAG_CLEAR_I, DIRECT_START_I, MASK_RETURN_I, CHANNEL_REQUEST_I, INTR_REQUEST_I, INTR_ACKNOWLEDGE_I;
	reg SYSTEM_PARITY_FAULT_I, MEMORY_ADDR_PARITY_FAULT_I, FAULT_CLEAR_I, IO_TRANSFER_ACTIVE_I;
	reg HIGH_WORD_SELECT_I, LOW_WORD_SELECT_I, go, slow;
	reg [11:0] PROC_WORD_I;
	reg [15:0] PROC_DATA_I, CDB_DATA_I, word, e, a;
	reg [15:0] w [0:1];
	reg [2:0] pcmd;
	wire SVC_IN_I, S_BUS_OE_O, IO_BUS_DATA_OE_O, IO_BUS_ADDR_OE_O, CDB_DATA_OE_O, SVC_OUT_O, PRIORITY_POLL_O;
	wire INTR_POLL_O, TRANSFER_ERROR_O, DONE_FLAG_O, HIGH_REQUEST_O, LOW_REQUEST_O, IN_BUF_READY_O;
	wire [15:0] IO_BUS_DATA_I, S_BUS_O, IO_BUS_DATA_O, CDB_DATA_O;
	wire [7:0] IO_BUS_DEVNUM_I, IO_BUS_DEVNUM_O;
	wire [2:0] IO_BUS_CMD_I, IO_BUS_CMD_O;
	wire [6:0] ev = {SVC_IN_I, INTR_POLL_O, HIGH_REQUEST_O, !IO_BUS_DATA_OE_O, IO_BUS_DATA_OE_O, IO_BUS_ADDR_OE_O,
		PRIORITY_POLL_O};
	integer n_fail, samples_checked, i, k;
	iorp_top iorp_top_i (.*);
	iorp_chan_model iorp_chan_model_i (.clk_i(REF_CLK_I), .rst_i(SYS_RST_I), .poll_i(PRIORITY_POLL_O),
		.addr_oe_i(IO_BUS_ADDR_OE_O), .data_oe_i(IO_BUS_DATA_OE_O), .go_i(go), .slow_i(slow), .word_i(word),
		.cmd_i(pcmd), .svc_in_o(SVC_IN_I), .bus_data_o(IO_BUS_DATA_I), .devnum_o(IO_BUS_DEVNUM_I),
		.bus_cmd_o(IO_BUS_CMD_I));
	task check(input [23:0] seen, input [23:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
			end
		end
	endtask
	task wait_on(input [2:0] s);
		begin
			k = 0;
			@(negedge REF_CLK_I);
			while (ev[s] !== 1'b1 && k < 300) begin
				@(negedge REF_CLK_I);
				k = k + 1;
			end
			if (k == 300)
				check(0, 1);
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d, mismatches %0d", samples_checked, n_fail);
			if (n_fail == 0 && samples_checked > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		REF_CLK_I = 0;
		forever #4 REF_CLK_I = ~REF_CLK_I;
	end
	initial begin
		repeat (20000) @(posedge REF_CLK_I);
		n_fail = n_fail + 1;
		end_of_test;
	end
	initial begin
		{COMMAND_REG_LOAD_I, DIRECT_DATA_LOAD_I, IO_COMMAND_CODE_I, DIRECT_IN_READ_I, DONE_FLAG_CLEAR_I,
			DIRECT_START_I, MASK_RETURN_I, CHANNEL_REQUEST_I, INTR_REQUEST_I, INTR_ACKNOWLEDGE_I, FAULT_CLEAR_I,
			SYSTEM_PARITY_FAULT_I, MEMORY_ADDR_PARITY_FAULT_I, IO_TRANSFER_ACTIVE_I, HIGH_WORD_SELECT_I,
			LOW_WORD_SELECT_I, go, slow, PROC_WORD_I, PROC_DATA_I, CDB_DATA_I, word, pcmd} = 0;
		SYS_RST_I = 1;
		n_fail = 0;
		samples_checked = 0;
		i = $urandom(32'h7CF7E8DB);
		repeat (5) @(posedge REF_CLK_I);
		SYS_RST_I <= 0;
		@(negedge REF_CLK_I);
		check({IN_BUF_READY_O, S_BUS_OE_O, IO_BUS_DATA_OE_O, IO_BUS_ADDR_OE_O, CDB_DATA_OE_O, SVC_OUT_O,
			PRIORITY_POLL_O, INTR_POLL_O, TRANSFER_ERROR_O, DONE_FLAG_O, HIGH_REQUEST_O}, 24'h000400);
		for (i = 0; i < 4; i = i + 1) begin
			@(posedge REF_CLK_I);
			PROC_WORD_I <= 12'($urandom) & 12'hFFE;
			PROC_DATA_I <= 16'($urandom);
			COMMAND_REG_LOAD_I <= 1;
			DIRECT_DATA_LOAD_I <= 1;
			slow <= i[0];
			@(posedge REF_CLK_I);
			COMMAND_REG_LOAD_I <= 0;
			DIRECT_DATA_LOAD_I <= 0;
			DIRECT_START_I <= 1;
			@(posedge REF_CLK_I);
			DIRECT_START_I <= 0;
			wait_on(1);
			check({IO_BUS_DEVNUM_O, IO_BUS_CMD_O}, PROC_WORD_I[11:1]);
			wait_on(2);
			check(IO_BUS_DATA_O, PROC_DATA_I);
			wait_on(3);
			@(negedge REF_CLK_I);
			check(DONE_FLAG_O, 1);
			@(posedge REF_CLK_I);
			DONE_FLAG_CLEAR_I <= 1;
			@(posedge REF_CLK_I);
			DONE_FLAG_CLEAR_I <= 0;
			@(negedge REF_CLK_I);
			check(DONE_FLAG_O, 0);
		end
		$display("direct test ends");
		for (i = 0; i < 2; i = i + 1) begin
			@(posedge REF_CLK_I);
			PROC_WORD_I <= {11'h000, !i[0]};
			COMMAND_REG_LOAD_I <= 1;
			@(posedge REF_CLK_I);
			COMMAND_REG_LOAD_I <= 0;
			@(posedge REF_CLK_I);
			@(posedge REF_CLK_I);
			@(negedge REF_CLK_I);
			check(SVC_OUT_O, !i[0]);
		end
		$display("service out test ends");
		@(posedge REF_CLK_I);
		INTR_REQUEST_I <= 1;
		word <= 16'($urandom);
		go <= 1;
		wait_on(5);
		@(posedge REF_CLK_I);
		INTR_ACKNOWLEDGE_I <= 1;
		@(posedge REF_CLK_I);
		INTR_ACKNOWLEDGE_I <= 0;
		INTR_REQUEST_I <= 0;
		go <= 0;
		IO_COMMAND_CODE_I <= 1;
		repeat (2) @(posedge REF_CLK_I);
		@(negedge REF_CLK_I);
		check({S_BUS_OE_O, S_BUS_O}, {1'b1, 8'h00, word[7:0]});
		@(posedge REF_CLK_I);
		IO_COMMAND_CODE_I <= 0;
		$display("interrupt test ends");
		e = 16'($urandom);
		a = 16'($urandom);
		@(posedge REF_CLK_I);
		CDB_DATA_I <= e;
		IO_TRANSFER_ACTIVE_I <= 1;
		word <= a;
		pcmd <= 3'h1;
		slow <= 1;
		@(posedge REF_CLK_I);
		IO_TRANSFER_ACTIVE_I <= 0;
		CHANNEL_REQUEST_I <= 1;
		wait_on(2);
		check({LOW_REQUEST_O, IO_BUS_DATA_O}, {1'b1, e});
		wait_on(4);
		repeat (4) @(posedge REF_CLK_I);
		HIGH_WORD_SELECT_I <= 1;
		@(posedge REF_CLK_I);
		HIGH_WORD_SELECT_I <= 0;
		@(negedge REF_CLK_I);
		check({CDB_DATA_OE_O, CDB_DATA_O}, {1'b1, e + 16'h0002});
		@(posedge REF_CLK_I);
		LOW_WORD_SELECT_I <= 1;
		DIRECT_IN_READ_I <= 1;
		@(posedge REF_CLK_I);
		LOW_WORD_SELECT_I <= 0;
		@(negedge REF_CLK_I);
		check({CDB_DATA_OE_O, CDB_DATA_O}, {1'b1, a});
		@(negedge REF_CLK_I);
		check({S_BUS_OE_O, S_BUS_O}, {1'b1, a});
		@(posedge REF_CLK_I);
		DIRECT_IN_READ_I <= 0;
		for (i = 0; i < 2; i = i + 1) begin
			@(posedge REF_CLK_I);
			w[i] = 16'($urandom);
			word <= w[i];
			go <= 1;
			pcmd <= 3'h0;
			// first word ends the waiting sequence; the second needs poll, address and data answers
			repeat (2 * i + 1) wait_on(6);
			@(posedge REF_CLK_I);
			go <= 0;
		end
		@(negedge REF_CLK_I);
		check({IN_BUF_READY_O, HIGH_REQUEST_O}, 2'b01);
		@(posedge REF_CLK_I);
		{SYSTEM_PARITY_FAULT_I, MEMORY_ADDR_PARITY_FAULT_I} <= 2'($urandom_range(1, 2));
		@(posedge REF_CLK_I);
		{SYSTEM_PARITY_FAULT_I, MEMORY_ADDR_PARITY_FAULT_I} <= 2'b00;
		repeat (2) @(posedge REF_CLK_I);
		@(negedge REF_CLK_I);
		check({TRANSFER_ERROR_O, SVC_OUT_O}, 2'b11);
		@(posedge REF_CLK_I);
		FAULT_CLEAR_I <= 1;
		@(posedge REF_CLK_I);
		FAULT_CLEAR_I <= 0;
		for (i = 0; i < 2; i = i + 1) begin
			@(posedge REF_CLK_I);
			HIGH_WORD_SELECT_I <= 1;
			@(posedge REF_CLK_I);
			HIGH_WORD_SELECT_I <= 0;
			@(negedge REF_CLK_I);
			check(CDB_DATA_O, w[i]);
		end
		check({HIGH_REQUEST_O, TRANSFER_ERROR_O}, 2'b00);
		CHANNEL_REQUEST_I <= 0;
		$display("multiplexed test ends");
		end_of_test;
	end
endmodule

// ### verification/iorp_chan_model.sv
// channel model on the far side of the i/o bus
// answers poll and gates with one service-in pulse after a short or long wait
`timescale 1ns/1ps
module iorp_chan_model (
	input wire clk_i,
	input wire rst_i,
	input wire poll_i,
	input wire addr_oe_i,
	input wire data_oe_i,
	input wire go_i,
	input wire slow_i,
	input wire [15:0] word_i,
	input wire [2:0] cmd_i,
	output reg svc_in_o,
	output wire [15:0] bus_data_o,
	output wire [7:0] devnum_o,
	output wire [2:0] bus_cmd_o
);
	reg [2:0] cnt;
	reg [15:0] last;
	reg owe;
	wire drive = svc_in_o | go_i;
	wire ask = poll_i | addr_oe_i | data_oe_i | go_i | owe;
	// a channel that answered a poll still owes the address word
	always @(posedge clk_i) begin
		if (rst_i)
			owe <= 1'b0;
		else if (svc_in_o)
			owe <= poll_i;
	end
	// answer poll
	// wait of three cycles at least, so a late gate change is never answered twice
	always @(posedge clk_i) begin
		if (rst_i || svc_in_o || !ask) begin
			svc_in_o <= 1'b0;
			cnt <= 3'h0;
		end else if (cnt >= (slow_i ? 3'h5 : 3'h2)) begin
			svc_in_o <= 1'b1;
		end else begin
			cnt <= cnt + 3'h1;
		end
	end
	// released lines show the inverse of the last word
	always @(posedge clk_i) begin
		if (rst_i)
			last <= 16'hA5A5;
		else if (drive)
			last <= word_i;
	end
	assign bus_data_o = drive ? word_i : ~last;
	assign devnum_o = drive ? word_i[7:0] : ~last[7:0];
	assign bus_cmd_o = cmd_i;
endmodule

// ### verification/iorp_top_sva.sv
// assertions on the register path ports
// bound to iorp_top; one clock, synchronous reset
`timescale 1ns/1ps
module iorp_top_sva (
	input wire REF_CLK_I,
	input wire SYS_RST_I,
	input wire [11:0] PROC_WORD_I,
	input wire COMMAND_REG_LOAD_I,
	input wire SVC_IN_I,
	input wire MASK_RETURN_I,
	input wire DONE_FLAG_CLEAR_I,
	input wire INTR_REQUEST_I,
	input wire HIGH_WORD_SELECT_I,
	input wire LOW_WORD_SELECT_I,
	input wire IO_BUS_DATA_OE_O,
	input wire IO_BUS_ADDR_OE_O,
	input wire [2:0] IO_BUS_CMD_O,
	input wire [7:0] IO_BUS_DEVNUM_O,
	input wire PRIORITY_POLL_O,
	input wire DONE_FLAG_O,
	input wire SVC_OUT_O,
	input wire INTR_POLL_O,
	input wire CDB_DATA_OE_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	reg [11:0] cmd;
	always @(posedge REF_CLK_I) begin
		if (COMMAND_REG_LOAD_I)
			cmd <= PROC_WORD_I;
	end
	property p_one_gate; !(IO_BUS_DATA_OE_O && IO_BUS_ADDR_OE_O); endproperty
	a_one_gate: assert property (p_one_gate) else $error("two bus gates on");
	property p_poll_hold; PRIORITY_POLL_O && !SVC_IN_I |=> !(IO_BUS_DATA_OE_O || IO_BUS_ADDR_OE_O); endproperty
	a_poll_hold: assert property (p_poll_hold) else $error("gate during poll");
	property p_gate_rise; $rose(IO_BUS_DATA_OE_O || IO_BUS_ADDR_OE_O) |-> $past(SVC_IN_I); endproperty
	a_gate_rise: assert property (p_gate_rise) else $error("gate rose without service in");
	property p_cmd_out; IO_BUS_ADDR_OE_O |-> {IO_BUS_DEVNUM_O, IO_BUS_CMD_O} == cmd[11:1]; endproperty
	a_cmd_out: assert property (p_cmd_out) else $error("wrong command or device");
	property p_svc_set; COMMAND_REG_LOAD_I && PROC_WORD_I[0] |-> ##3 SVC_OUT_O; endproperty
	a_svc_set: assert property (p_svc_set) else $error("service out missing");
	property p_done_set; $rose(DONE_FLAG_O) |-> $past(SVC_IN_I || SVC_OUT_O || MASK_RETURN_I); endproperty
	a_done_set: assert property (p_done_set) else $error("done flag without event");
	property p_done_clr; DONE_FLAG_CLEAR_I && !(SVC_IN_I || SVC_OUT_O || MASK_RETURN_I) |=> !DONE_FLAG_O; endproperty
	a_done_clr: assert property (p_done_clr) else $error("done flag not cleared");
	property p_cdb_src; CDB_DATA_OE_O |-> $past(HIGH_WORD_SELECT_I || LOW_WORD_SELECT_I); endproperty
	a_cdb_src: assert property (p_cdb_src) else $error("data bus driven unselected");
	property p_intr_poll; $rose(INTR_POLL_O) |-> $past(INTR_REQUEST_I); endproperty
	a_intr_poll: assert property (p_intr_poll) else $error("poll without request");
endmodule
bind iorp_top iorp_top_sva iorp_top_sva_i (.*);
